/* File: hdl/gpw_regs.svh */
`ifndef GPW_REGS_SVH
`define GPW_REGS_SVH
// Byte offsets on the register bus
`define GPW_OFS_IRQ_EN 8'h00
`define GPW_OFS_IRQ_KIND 8'h04
`define GPW_OFS_DB_EN 8'h08
`define GPW_OFS_DB_CTL 8'h0C
`define GPW_OFS_FLAG 8'h10
`define GPW_OFS_PIN 8'h14
`define GPW_OFS_MODE 8'h18
`define GPW_OFS_PULL 8'h1C
`define GPW_OFS_DOUT 8'h20
// Field positions and widths
`define GPW_RISE_BIT 16
`define GPW_DBCTL_SRC 4
`define GPW_DBCTL_PER_HI 3
`define GPW_DBCTL_W 5
`define GPW_DEF_MODE_BIT 10
// Pin mode codes, two bits per pin
`define GPW_MODE_IN 2'h0
`define GPW_MODE_PP 2'h1
`define GPW_MODE_OD 2'h2
`define GPW_MODE_QB 2'h3
// Bus answers, reset values and the debounce counter width
`define GPW_RESP_OKAY 2'h0
`define GPW_RESP_SLVERR 2'h2
`define GPW_ZERO32 32'h0000_0000
`define GPW_CNT_W 16
`endif

/* File: hdl/gpw_pkg.sv */
package gpw_pkg;
`include "gpw_regs.svh"

  typedef enum logic [3:0] {
    GPW_R_IRQ_EN, GPW_R_IRQ_KIND, GPW_R_DB_EN, GPW_R_DB_CTL, GPW_R_FLAG,
    GPW_R_PIN, GPW_R_MODE, GPW_R_PULL, GPW_R_DOUT, GPW_R_NONE
  } gpw_reg_t;

  // Shared by read and write paths
  function automatic gpw_reg_t gpw_decode(input logic [7:0] addr);
    case (addr)
      `GPW_OFS_IRQ_EN: gpw_decode = GPW_R_IRQ_EN;
      `GPW_OFS_IRQ_KIND: gpw_decode = GPW_R_IRQ_KIND;
      `GPW_OFS_DB_EN: gpw_decode = GPW_R_DB_EN;
      `GPW_OFS_DB_CTL: gpw_decode = GPW_R_DB_CTL;
      `GPW_OFS_FLAG: gpw_decode = GPW_R_FLAG;
      `GPW_OFS_PIN: gpw_decode = GPW_R_PIN;
      `GPW_OFS_MODE: gpw_decode = GPW_R_MODE;
      `GPW_OFS_PULL: gpw_decode = GPW_R_PULL;
      `GPW_OFS_DOUT: gpw_decode = GPW_R_DOUT;
      default: gpw_decode = GPW_R_NONE;
    endcase
  endfunction : gpw_decode
endpackage : gpw_pkg

/* File: hdl/gpw_cfg_if.sv */
`timescale 1ns/1ps
interface gpw_cfg_if #(parameter int N = 16);
  logic [N-1:0] rise_high_irq_enable;
  logic [N-1:0] fall_low_irq_enable;
  logic [N-1:0] kind_level;
  logic [N-1:0] db_en;
  logic debounce_clock_source;
  logic [3:0] debounce_sample_period;
  logic slow_tick;
  logic sleep;
  logic [N-1:0] ev;
  logic wake_ev;
  modport ctl (output rise_high_irq_enable, fall_low_irq_enable, kind_level,
    db_en, debounce_clock_source, debounce_sample_period, slow_tick, sleep,
    input ev, wake_ev);
  modport det (input rise_high_irq_enable, fall_low_irq_enable, kind_level,
    db_en, debounce_clock_source, debounce_sample_period, slow_tick, sleep,
    output ev, wake_ev);
endinterface : gpw_cfg_if

/* File: hdl/gpw_detect.sv */
`timescale 1ns/1ps
`include "gpw_regs.svh"
module gpw_detect import gpw_pkg::*; #(
  parameter int N = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] pin_s,
  gpw_cfg_if.det cfg
);
  logic [`GPW_CNT_W-1:0] cnt_q, cnt_d;
  logic [N-1:0] samp_q, samp_d, db_q, db_d, prev_q, raw_q, ev_q, ev_d;
  logic wake_q, wake_d;
  logic src_tick, samp_now;
  logic [N-1:0] filt, hit, wake_hit;

  // Sample period is 2^sel source cycles
  function automatic logic [`GPW_CNT_W-1:0] per_lim(input logic [3:0] sel);
    per_lim = (`GPW_CNT_W'(1) << sel) - `GPW_CNT_W'(1);
  endfunction : per_lim

  // Debounce sampler, edge/level detect and wake-up path
  always_comb begin
    src_tick = cfg.debounce_clock_source ? cfg.slow_tick : 1'b1;
    samp_now = src_tick && (cnt_q == per_lim(cfg.debounce_sample_period));
    cnt_d = cnt_q;
    if (src_tick) begin
      cnt_d = samp_now ? '0 : cnt_q + `GPW_CNT_W'(1);
    end
    samp_d = samp_now ? pin_s : samp_q;
    db_d = db_q;
    if (samp_now) begin
      // Two equal samples in a row before the filtered value moves
      db_d = (pin_s & ~(pin_s ^ samp_q)) | (db_q & (pin_s ^ samp_q));
    end
    filt = (cfg.db_en & db_q) | (~cfg.db_en & pin_s);
    for (int i = 0; i < N; i++) begin
      if (cfg.kind_level[i]) begin
        // Level sense ignores the filter; it only guards edges
        hit[i] = (pin_s[i] & cfg.rise_high_irq_enable[i]) |
                 (~pin_s[i] & cfg.fall_low_irq_enable[i]);
        wake_hit[i] = hit[i];
      end else begin
        hit[i] = (filt[i] & ~prev_q[i] & cfg.rise_high_irq_enable[i]) |
                 (~filt[i] & prev_q[i] & cfg.fall_low_irq_enable[i]);
        wake_hit[i] = (pin_s[i] & ~raw_q[i] & cfg.rise_high_irq_enable[i]) |
                      (~pin_s[i] & raw_q[i] & cfg.fall_low_irq_enable[i]);
      end
    end
    // Wake uses the same trigger setting, raw; filtered path adds its own
    ev_d = hit | (cfg.sleep ? wake_hit : '0);
    wake_d = cfg.sleep && (|wake_hit);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      samp_q <= '0;
      db_q <= '0;
      prev_q <= '0;
      raw_q <= '0;
      ev_q <= '0;
      wake_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      samp_q <= samp_d;
      db_q <= db_d;
      prev_q <= filt;
      raw_q <= pin_s;
      ev_q <= ev_d;
      wake_q <= wake_d;
    end
  end

  assign cfg.ev = ev_q;
  assign cfg.wake_ev = wake_q;

  // Setup must hold across both cycles, or a rewrite could fake a miss
  sequence s_rise0;
    (!cfg.kind_level[0] && !cfg.db_en[0] && cfg.rise_high_irq_enable[0]
      && !pin_s[0]) ##1 (!cfg.kind_level[0] && !cfg.db_en[0]
      && cfg.rise_high_irq_enable[0] && pin_s[0]);
  endsequence

  a_rise_edge_event: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rise0 |=> cfg.ev[0])
    else $error("rising edge on pin 0 gave no event");
  a_level_event: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.kind_level[0] && cfg.fall_low_irq_enable[0] && !pin_s[0]
      |=> cfg.ev[0])
    else $error("low level on pin 0 gave no event");
  a_wake_needs_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.wake_ev |-> $past(cfg.sleep))
    else $error("wake event outside sleep");
  a_db_holds_glitch: assert property (@(posedge aclk) disable iff (!aresetn)
    !samp_now |=> $stable(db_q))
    else $error("filtered value moved between samples");
endmodule : gpw_detect

/* File: hdl/gpw_top.sv */
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "gpw_regs.svh"
module gpw_top import gpw_pkg::*; #(
  parameter int N = 16,
  parameter bit PORT_A = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N-1:0] pin_i,
  output logic [N-1:0] pin_o,
  output logic [N-1:0] pin_oe_n,
  output logic [N-1:0] pull_up_en,
  output logic [N-1:0] pull_dn_en,
  input wire logic slow_clk,
  input wire logic sleep_req,
  input wire logic [31:0] user_config_word_zero,
  output logic irq,
  output logic wake
);
  // Pins map onto the 16-bit halves of the enable and pull words
  if (N < 1 || N > 16) begin : g_bad_n
    $error("gpw_top: N must be 1..16");
  end

  gpw_cfg_if #(.N(N)) cfg ();

  // Registers
  logic [31:0] en_q, en_d, pull_q, pull_d, mode_q, mode_d;
  logic [N-1:0] kind_q, kind_d, dben_q, dben_d, flag_q, flag_d;
  logic [N-1:0] dout_q, dout_d;
  logic [`GPW_DBCTL_W-1:0] dbctl_q, dbctl_d;
  logic init_q;
  // Synchronisers
  logic [N-1:0] pin_m_q, pin_s_q;
  logic slow_m_q, slow_s_q, slow_p_q;
  // Bus slave
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_d, wmask;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic do_wr, rd_take;
  logic [N-1:0] clr;
  // Pads
  logic [N-1:0] po_d, poe_d, pu_d, pd_d;
  logic irq_d;

  assign cfg.rise_high_irq_enable = en_q[`GPW_RISE_BIT +: N];
  assign cfg.fall_low_irq_enable = en_q[N-1:0];
  assign cfg.kind_level = kind_q;
  assign cfg.db_en = dben_q;
  assign cfg.debounce_clock_source = dbctl_q[`GPW_DBCTL_SRC];
  assign cfg.debounce_sample_period = dbctl_q[`GPW_DBCTL_PER_HI:0];
  assign cfg.slow_tick = slow_s_q & ~slow_p_q;
  assign cfg.sleep = sleep_req;

  gpw_detect #(.N(N)) u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_s(pin_s_q),
    .cfg(cfg)
  );

  // Pins and the slow clock are asynchronous: two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      slow_m_q <= 1'b0;
      slow_s_q <= 1'b0;
      slow_p_q <= 1'b0;
    end else begin
      pin_m_q <= pin_i;
      pin_s_q <= pin_m_q;
      slow_m_q <= slow_clk;
      slow_s_q <= slow_m_q;
      slow_p_q <= slow_s_q;
    end
  end

  // Bus handshake: address and data taken in either order
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
    end
    bvalid_d = do_wr | (s_axi_bvalid & ~s_axi_bready);
    bresp_d = s_axi_bresp;
    if (do_wr) begin
      bresp_d = (gpw_decode(awaddr_q) == GPW_R_NONE) ?
        `GPW_RESP_SLVERR : `GPW_RESP_OKAY;
    end
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstrb_q[b]}};
    end
  end

  // Register writes; flag bits clear on write of one
  always_comb begin
    en_d = en_q;
    kind_d = kind_q;
    dben_d = dben_q;
    dbctl_d = dbctl_q;
    pull_d = pull_q;
    mode_d = mode_q;
    dout_d = dout_q;
    clr = '0;
    if (!init_q) begin
      // Default pin mode from the configuration word, once after reset
      mode_d = user_config_word_zero[`GPW_DEF_MODE_BIT] ?
        {16{`GPW_MODE_IN}} : {16{`GPW_MODE_QB}};
    end else if (do_wr) begin
      unique case (gpw_decode(awaddr_q))
        GPW_R_IRQ_EN: en_d = (en_q & ~wmask) | (wdata_q & wmask);
        GPW_R_IRQ_KIND: kind_d = N'((kind_q & ~wmask) | (wdata_q & wmask));
        GPW_R_DB_EN: dben_d = N'((dben_q & ~wmask) | (wdata_q & wmask));
        GPW_R_DB_CTL: begin
          if (wstrb_q[0]) begin
            dbctl_d = wdata_q[`GPW_DBCTL_W-1:0];
          end
        end
        GPW_R_FLAG: clr = N'(wdata_q & wmask);
        GPW_R_MODE: mode_d = (mode_q & ~wmask) | (wdata_q & wmask);
        GPW_R_PULL: pull_d = (pull_q & ~wmask) | (wdata_q & wmask);
        GPW_R_DOUT: dout_d = N'((dout_q & ~wmask) | (wdata_q & wmask));
        GPW_R_PIN, GPW_R_NONE: ;
      endcase
    end
    // A new event beats a clear in the same cycle
    flag_d = (flag_q & ~clr) | cfg.ev;
    irq_d = |flag_d;
  end

  // Read channel: one cycle from address to data
  always_comb begin
    rd_take = s_axi_arvalid && s_axi_arready;
    rvalid_d = rd_take | (s_axi_rvalid & ~s_axi_rready);
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    if (rd_take) begin
      rresp_d = `GPW_RESP_OKAY;
      unique case (gpw_decode(s_axi_araddr))
        GPW_R_IRQ_EN: rdata_d = en_q;
        GPW_R_IRQ_KIND: rdata_d = 32'(kind_q);
        GPW_R_DB_EN: rdata_d = 32'(dben_q);
        GPW_R_DB_CTL: rdata_d = 32'(dbctl_q);
        GPW_R_FLAG: rdata_d = 32'(flag_q);
        GPW_R_PIN: rdata_d = 32'(pin_s_q);
        GPW_R_MODE: rdata_d = mode_q;
        GPW_R_PULL: rdata_d = pull_q;
        GPW_R_DOUT: rdata_d = 32'(dout_q);
        GPW_R_NONE: begin
          rdata_d = `GPW_ZERO32;
          rresp_d = `GPW_RESP_SLVERR;
        end
      endcase
    end
  end

  // Pad drive and pulls; quasi mode relies on the weak pull for high
  always_comb begin
    for (int i = 0; i < N; i++) begin
      po_d[i] = 1'b0;
      poe_d[i] = 1'b1;
      unique case (mode_d[2*i +: 2])
        `GPW_MODE_IN: poe_d[i] = 1'b1;
        `GPW_MODE_PP: begin
          po_d[i] = dout_d[i];
          poe_d[i] = 1'b0;
        end
        `GPW_MODE_OD, `GPW_MODE_QB: poe_d[i] = dout_d[i];
      endcase
      if (PORT_A) begin
        pu_d[i] = pull_d[i];
        pd_d[i] = pull_d[`GPW_RISE_BIT + i];
      end else begin
        pu_d[i] = (mode_d[2*i +: 2] == `GPW_MODE_QB);
        pd_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= `GPW_ZERO32;
      kind_q <= '0;
      dben_q <= '0;
      dbctl_q <= '0;
      pull_q <= `GPW_ZERO32;
      mode_q <= `GPW_ZERO32;
      dout_q <= '0;
      flag_q <= '0;
      init_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= `GPW_ZERO32;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPW_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `GPW_ZERO32;
      s_axi_rresp <= `GPW_RESP_OKAY;
      pin_o <= '0;
      pin_oe_n <= '1;
      pull_up_en <= '0;
      pull_dn_en <= '0;
      irq <= 1'b0;
      wake <= 1'b0;
    end else begin
      en_q <= en_d;
      kind_q <= kind_d;
      dben_q <= dben_d;
      dbctl_q <= dbctl_d;
      pull_q <= pull_d;
      mode_q <= mode_d;
      dout_q <= dout_d;
      flag_q <= flag_d;
      init_q <= 1'b1;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= !aw_have_d && !bvalid_d;
      s_axi_wready <= !w_have_d && !bvalid_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
      pin_o <= po_d;
      pin_oe_n <= poe_d;
      pull_up_en <= pu_d;
      pull_dn_en <= pd_d;
      irq <= irq_d;
      wake <= cfg.wake_ev;
    end
  end

  sequence s_write_done;
    aw_have_q && w_have_q && !s_axi_bvalid;
  endsequence

  a_set_beats_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.ev != '0) |=> ((flag_q & $past(cfg.ev)) == $past(cfg.ev)))
    else $error("event lost against clear");
  a_flag_sticks: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_q[0] && !(do_wr && gpw_decode(awaddr_q) == GPW_R_FLAG)
      |=> flag_q[0])
    else $error("flag dropped without a clear");
  a_irq_from_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (|flag_q) |-> irq)
    else $error("flag set but irq low");
  a_mode_default: assert property (@(posedge aclk) disable iff (!aresetn)
    !init_q |=> mode_q == (user_config_word_zero[`GPW_DEF_MODE_BIT] ?
      {16{`GPW_MODE_IN}} : {16{`GPW_MODE_QB}}))
    else $error("default pin mode wrong after reset");
  a_pull_dn_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    (pull_dn_en & ~(PORT_A ? pull_q[`GPW_RISE_BIT +: N] : '0)) == '0)
    else $error("pull-down on without its enable");
  a_bresp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_done |=> s_axi_bvalid)
    else $error("write answer missing");
endmodule : gpw_top

/* File: dv/gpw_pin_model.sv */
`timescale 1ns/1ps
// Stand-in for whatever drives the pads from outside the chip
module gpw_pin_model #(
  parameter int N = 16
) (
  input wire logic aclk,
  input wire logic [N-1:0] want,
  input wire logic [N-1:0] glitch,
  input wire logic [N-1:0] pin_o,
  input wire logic [N-1:0] pin_oe_n,
  output logic [N-1:0] pin_i
);
  logic [N-1:0] ext_q = {N{1'h0}};
  // Registered so a level change always lands just after a sampling edge
  always @(posedge aclk) begin
    ext_q <= want ^ glitch;
  end
  // Chip wins where it drives, outside level elsewhere
  assign pin_i = (pin_o & ~pin_oe_n) | (ext_q & pin_oe_n);
endmodule : gpw_pin_model

/* File: dv/gpio_pin_interrupt_wakeup_tb.sv */
`timescale 1ns/1ps
`include "gpw_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module gpio_pin_interrupt_wakeup_tb;
  logic aclk = 1'h0, aresetn = 1'h0, slow_clk = 1'h0, slow_run = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic rready = 1'h0, sleep_req = 1'h0, awready, wready, bvalid, arready;
  logic rvalid, irq, wake;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, cfg0 = 32'h0, rdata, d, v;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic [15:0] pin_i, pin_o, pin_oe_n, pull_up_en, pull_dn_en;
  logic [15:0] want = 16'h0, glitch = 16'h0;
  int n_errors = 0, n_checks = 0, wcnt = 0, cyc = 0, n;

  // Main clock, 4 ns period
  initial forever #2 aclk = ~aclk;
  // Slow clock stops when idle, so a dead source shows
  initial forever #13 slow_clk = slow_run ? ~slow_clk : 1'h0;

  gpw_top #(.N(16), .PORT_A(1'h1)) i_gpw_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .slow_clk(slow_clk), .sleep_req(sleep_req),
    .user_config_word_zero(cfg0), .irq(irq), .wake(wake));

  gpw_pin_model #(.N(16)) i_gpw_pin_model (.aclk(aclk), .want(want),
    .glitch(glitch), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_i(pin_i));

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // Wake pulse counter and run-time ceiling
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (wake === 1'h1) wcnt <= wcnt + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic wt(input int k);
    repeat (k) @(posedge aclk);
  endtask : wt

  // Write: address and data released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] x,
                    input logic [3:0] s);
    int t;
    t = 0;
    awaddr <= a;
    wdata <= x;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      t++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && t < 50);
    // bready stays up, so a following write never sets it twice at once
    r = bresp;
    if (t >= 50) n_errors++;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      t++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && t < 50);
    d = rdata;
    r = rresp;
    if (t >= 50) n_errors++;
  endtask : rd

  task automatic rst(input logic b);
    cfg0 <= $urandom & 32'hFFFF_FBFF | {21'h0, b, 10'h0};
    aresetn <= 1'h0;
    wt(16);
    aresetn <= 1'h1;
    wt(1);
  endtask : rst

  // Pin n trigger: 0 low, 1 high, 2 fall, 3 rise, 4 both; flags cleared
  task automatic setm(input int m);
    logic [31:0] en;
    en = {15'h0, m == 1 || m >= 3, 15'h0, m == 0 || m == 2 || m == 4};
    wr(`GPW_OFS_IRQ_EN, 32'h0, 4'hF);
    wr(`GPW_OFS_IRQ_KIND, {31'h0, m < 2} << n, 4'hF);
    wr(`GPW_OFS_IRQ_EN, en << n, 4'hF);
    wr(`GPW_OFS_FLAG, 32'hFFFF_FFFF, 4'hF);
  endtask : setm

  // Level flags re-set after a clear while the level holds; edge flags do not
  function automatic logic exp_flag(input int m, input logic up,
                                    input logic clr);
    if (m < 2) return clr ? (up == m[0]) : 1'h1;
    return clr ? 1'h0 : (m == 4 || up == m[0]);
  endfunction : exp_flag

  initial begin
    void'($urandom(32'h2945_D531));
    for (int b = 0; b < 2; b++) begin
      rst(b[0]);
      rd(`GPW_OFS_MODE);
      `CHK("mode", b ? 32'h0 : 32'hFFFF_FFFF, d)
      rd(`GPW_OFS_IRQ_EN);
      `CHK("irq_en", 32'h0, d)
    end
    // Unmapped offsets answer with an error and zero data
    rd(8'h24);
    `CHK("rresp", `GPW_RESP_SLVERR, r)
    `CHK("rdata", 32'h0, d)
    wr(8'h3C, 32'hFFFF_FFFF, 4'hF);
    `CHK("bresp", `GPW_RESP_SLVERR, r)
    // Five control bits, written only with byte 0 strobed
    wr(`GPW_OFS_DB_CTL, 32'hFFFF_FFFF, 4'hF);
    rd(`GPW_OFS_DB_CTL);
    `CHK("db_ctl", 32'h1F, d)
    wr(`GPW_OFS_DB_CTL, 32'h0, 4'hE);
    rd(`GPW_OFS_DB_CTL);
    `CHK("db_ctl strobe", 32'h1F, d)
    wr(`GPW_OFS_DB_CTL, 32'h0, 4'hF);
    // Pads and port A pulls in push-pull, open-drain and input mode
    v = $urandom;
    wr(`GPW_OFS_PULL, v, 4'hF);
    wr(`GPW_OFS_DOUT, v, 4'hF);
    for (int k = 0; k < 3; k++) begin
      wr(`GPW_OFS_MODE, k == 0 ? 32'h5555_5555 : k == 1 ? 32'hAAAA_AAAA :
         32'h0, 4'hF);
      wt(2);
      `CHK("pull_up", v[15:0], pull_up_en)
      `CHK("pull_dn", v[31:16], pull_dn_en)
      `CHK("pin_o", k == 0 ? v[15:0] : 16'h0, pin_o)
      `CHK("pin_oe_n", k == 0 ? 16'h0 : k == 1 ? v[15:0] : 16'hFFFF, pin_oe_n)
    end
    // Every trigger kind against a rise and a fall
    for (int m = 0; m < 5; m++) begin
      for (int u = 0; u < 2; u++) begin
        // Pin 0 for low level and rising edge, so pin-0 checks see use
        n = (m == 0 || m == 3) ? 0 : $urandom_range(15, 0);
        v = $urandom;
        v[n] = ~u[0];
        want <= v[15:0];
        wt(6);
        setm(m);
        wcnt = 0;
        want[n] <= u[0];
        wt(10);
        rd(`GPW_OFS_FLAG);
        `CHK("flag", exp_flag(m, u[0], 1'h0), d[n])
        `CHK("irq", exp_flag(m, u[0], 1'h0), irq)
        wr(`GPW_OFS_FLAG, 32'h1 << n, 4'hF);
        wt(4);
        rd(`GPW_OFS_FLAG);
        `CHK("flag clear", exp_flag(m, u[0], 1'h1), d[n])
        `CHK("wake awake", 0, wcnt)
      end
    end
    // One-cycle glitch is filtered on a rising-edge pin
    want[n] <= 1'h0;
    wr(`GPW_OFS_DB_EN, 32'h1 << n, 4'hF);
    wt(10);
    setm(3);
    glitch[n] <= 1'h1;
    wt(1);
    glitch[n] <= 1'h0;
    wt(20);
    rd(`GPW_OFS_FLAG);
    `CHK("glitch", 1'h0, d[n])
    // Slow source: no ticks, no event; ticks running, event
    wr(`GPW_OFS_DB_CTL, 32'h10, 4'hF);
    want[n] <= 1'h1;
    wt(40);
    rd(`GPW_OFS_FLAG);
    `CHK("slow stopped", 1'h0, d[n])
    slow_run = 1'h1;
    wt(60);
    rd(`GPW_OFS_FLAG);
    `CHK("slow running", 1'h1, d[n])
    slow_run = 1'h0;
    // Period code 5 on aclk: 32 cycles between samples
    wr(`GPW_OFS_DB_CTL, 32'h05, 4'hF);
    want[n] <= 1'h0;
    wt(100);
    wr(`GPW_OFS_FLAG, 32'hFFFF_FFFF, 4'hF);
    want[n] <= 1'h1;
    wt(12);
    rd(`GPW_OFS_FLAG);
    `CHK("period early", 1'h0, d[n])
    wt(100);
    rd(`GPW_OFS_FLAG);
    `CHK("period late", 1'h1, d[n])
    // Sleep wake-up with the filter left on, then switched off
    for (int b = 1; b >= 0; b--) begin
      wr(`GPW_OFS_DB_EN, {31'h0, b[0]} << n, 4'hF);
      want[n] <= 1'h0;
      wt(100);
      wr(`GPW_OFS_FLAG, 32'hFFFF_FFFF, 4'hF);
      sleep_req <= 1'h1;
      wcnt = 0;
      want[n] <= 1'h1;
      wt(8);
      `CHK("wake", 1, wcnt)
      rd(`GPW_OFS_FLAG);
      `CHK("raw flag", 1'h1, d[n])
      sleep_req <= 1'h0;
      wr(`GPW_OFS_FLAG, 32'h1 << n, 4'hF);
      wt(100);
      rd(`GPW_OFS_FLAG);
      `CHK("second event", b[0], d[n])
    end
    results();
  end
endmodule : gpio_pin_interrupt_wakeup_tb
